// [rtl/pcw_defs.svh]
// register map, field positions, reset values and counts of the power control block
`ifndef PCW_DEFS_SVH
`define PCW_DEFS_SVH
// byte offsets
`define PCW_OFF_PWR      6'h00
`define PCW_OFF_FASTCLK  6'h04
`define PCW_OFF_PERCLK   6'h08
`define PCW_OFF_PDSTATE  6'h0c
`define PCW_OFF_SELA     6'h10
`define PCW_OFF_SELB     6'h14
`define PCW_OFF_DIV      6'h18
`define PCW_OFF_SELC     6'h1c
`define PCW_OFF_SLEEP    6'h20
`define PCW_OFF_PSTF     6'h24
`define PCW_OFF_DBGPD    6'h28
`define PCW_OFF_IRQSTS   6'h2c
`define PCW_OFF_IRQMSK   6'h30
// power control field positions
`define PCW_B_LATTMR     31:28
`define PCW_B_PORF       26
`define PCW_B_TMRF       25
`define PCW_B_PINF       24
`define PCW_B_SELTMR     23:20
`define PCW_B_SLOWOFF    17
`define PCW_B_PINDIS     16
`define PCW_B_DPDREQ     11
`define PCW_B_SPDREQ     10
`define PCW_B_STOP       9
`define PCW_B_SLOWEN     3
`define PCW_B_FASTEN     2
`define PCW_B_XTALEN     1
// reset values
`define PCW_RST_FASTCLK  3'h5
`define PCW_RST_PERCLK   32'h00000000
`define PCW_RST_SELA     32'h00000038
`define PCW_RST_SELB     32'h3300771f
`define PCW_RST_DIV      32'h00000000
`define PCW_RST_SELC     32'hffffffff
`define PCW_RST_SLEEP    32'hffffffff
`define PCW_RST_PSTF     32'h00000000
`define PCW_RST_DBGPD    32'h00000000
// wake timer counts in slow oscillator cycles, one per select bit
`define PCW_TMR_CNT0     11'h080
`define PCW_TMR_CNT1     11'h100
`define PCW_TMR_CNT2     11'h200
`define PCW_TMR_CNT3     11'h400
// interrupt status bits
`define PCW_IRQ_WAKE     0
`define PCW_IRQ_REFUSE   1
`define PCW_IRQ_LOCKED   2
`endif

// [rtl/pcw_pkg.sv]
// types of the power control and wake block
`default_nettype none
package pcw_pkg;
  // power manager states, gray along run -> deep -> wake
  typedef enum logic [1:0] {
    PCW_RUN  = 2'h0,
    PCW_DEEP = 2'h1,
    PCW_WAKE = 2'h3,
    PCW_STBY = 2'h2
  } pcw_pm_e_t;

  typedef struct packed {
    logic [3:0] lat_tmr;
    logic       por_f;
    logic       tmr_f;
    logic       pin_f;
    logic [3:0] sel_tmr;
    logic       slow_off;
    logic       pin_dis;
    logic       dpd_req;
    logic       spd_req;
    logic       stop;
    logic       slow_en;
    logic       fast_en;
    logic       xtal_en;
  } pcw_pwr_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_pend;
    logic        w_pend;
    logic [5:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    pcw_pwr_t    pwr;
    logic [2:0]  fastclk;
    logic [7:0][31:0] misc;
    logic [7:0]  pd_wr;
    logic [7:0]  pd_rd;
    pcw_pm_e_t   pm;
    logic [10:0] tmr_cnt;
    logic        pin_prev;
    logic        slow_run;
    logic        restart;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_msk;
    logic        irq;
    logic        deep;
    logic        stby;
  } pcw_state_t;
endpackage : pcw_pkg
`default_nettype wire

// [rtl/pcw_power_ctrl.sv]
// power control, wake logic and clock gating registers behind an axi4-lite slave
`include "pcw_defs.svh"
`default_nettype none
module pcw_power_ctrl
  import pcw_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // system side
  input  wire logic        regs_unlocked,
  input  wire logic        core_wait_instr,
  input  wire logic        debug_active,
  input  wire logic        slow_osc_tick,
  input  wire logic        wake_pin,
  input  wire logic        por_event,
  input  wire logic        standby_wake,
  // power and clock controls
  output var  logic        slow_osc_run,
  output var  logic        fast_osc_enable,
  output var  logic        crystal_osc_enable,
  output var  logic        flash_program_clock_enable,
  output var  logic        dma_clock_enable,
  output var  logic        cpu_clock_enable,
  output var  logic        deep_power_down,
  output var  logic        standby_power_down,
  output var  logic        core_restart,
  output var  logic        irq
);

  pcw_state_t st_reg;
  pcw_state_t st_next;
  logic       wr_do;
  logic       rd_do;
  logic       wr_lock;
  logic       tmr_hit;
  logic       pin_fall;
  logic [10:0] tmr_target;

  // byte-lane merge for writes
  function automatic logic [31:0] pcw_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : pcw_merge

  // power control image as software reads it; reserved bits are zero
  function automatic logic [31:0] pcw_pwr_word(input pcw_pwr_t p);
    logic [31:0] w;
    w = 32'h00000000;
    w[`PCW_B_LATTMR] = p.lat_tmr;
    w[`PCW_B_PORF]   = p.por_f;
    w[`PCW_B_TMRF]   = p.tmr_f;
    w[`PCW_B_PINF]   = p.pin_f;
    w[`PCW_B_SELTMR] = p.sel_tmr;
    w[`PCW_B_SLOWOFF] = p.slow_off;
    w[`PCW_B_PINDIS] = p.pin_dis;
    w[`PCW_B_DPDREQ] = p.dpd_req;
    w[`PCW_B_SPDREQ] = p.spd_req;
    w[`PCW_B_STOP]   = p.stop;
    w[`PCW_B_SLOWEN] = p.slow_en;
    w[`PCW_B_FASTEN] = p.fast_en;
    w[`PCW_B_XTALEN] = p.xtal_en;
    return w;
  endfunction : pcw_pwr_word

  // select to count; the shortest selected delay fires first
  always_comb begin
    if (st_reg.pwr.lat_tmr[0]) begin
      tmr_target = `PCW_TMR_CNT0;
    end else if (st_reg.pwr.lat_tmr[1]) begin
      tmr_target = `PCW_TMR_CNT1;
    end else if (st_reg.pwr.lat_tmr[2]) begin
      tmr_target = `PCW_TMR_CNT2;
    end else begin
      tmr_target = `PCW_TMR_CNT3;
    end
  end

  // wake sources seen while in deep power down
  // gated timer
  assign tmr_hit  = (st_reg.pm == PCW_DEEP) && slow_osc_tick && st_reg.slow_run &&
                    (st_reg.pwr.lat_tmr != 4'h0) &&
                    (11'(st_reg.tmr_cnt + 11'h001) == tmr_target);
  assign pin_fall = (st_reg.pm == PCW_DEEP) && st_reg.pin_prev && !wake_pin &&
                    !st_reg.pwr.pin_dis;
  assign wr_do    = st_reg.aw_pend && st_reg.w_pend && !st_reg.bvalid;
  assign rd_do    = s_axi_arvalid && st_reg.arready;
  assign wr_lock  = wr_do && !regs_unlocked &&
                    (st_reg.awaddr == `PCW_OFF_PWR || st_reg.awaddr == `PCW_OFF_FASTCLK);

  // next state of the whole block
  always_comb begin
    logic [31:0] wv;
    logic [2:0]  ev;
    logic [31:0] rv;
    logic        rerr;
    wv = 32'h00000000;
    ev = 3'h0;
    rv = 32'h00000000;
    rerr = 1'b0;
    st_next = st_reg;
    st_next.restart = 1'b0;
    st_next.pin_prev = wake_pin;

    // write address and data are taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_pend = 1'b1;
      st_next.awaddr  = {s_axi_awaddr[5:2], 2'h0};
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_pend = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // register writes; a locked write is dropped and answered slverr
    if (wr_do) begin
      st_next.aw_pend = 1'b0;
      st_next.w_pend  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = 2'h0;
      if (wr_lock) begin
        st_next.bresp = 2'h2;
        ev[`PCW_IRQ_LOCKED] = 1'b1;
      end else begin
        case (st_reg.awaddr)
          `PCW_OFF_PWR: begin
            wv = pcw_merge(pcw_pwr_word(st_reg.pwr), st_reg.wdata, st_reg.wstrb);
            // read-only fields lat_tmr and wake flags are not touched
            st_next.pwr.sel_tmr  = wv[`PCW_B_SELTMR];
            st_next.pwr.slow_off = wv[`PCW_B_SLOWOFF];
            st_next.pwr.pin_dis  = wv[`PCW_B_PINDIS];
            st_next.pwr.dpd_req  = wv[`PCW_B_DPDREQ];
            st_next.pwr.spd_req  = wv[`PCW_B_SPDREQ];
            st_next.pwr.stop     = wv[`PCW_B_STOP];
            st_next.pwr.slow_en  = wv[`PCW_B_SLOWEN];
            st_next.pwr.fast_en  = wv[`PCW_B_FASTEN];
            st_next.pwr.xtal_en  = wv[`PCW_B_XTALEN];
          end
          `PCW_OFF_FASTCLK: begin
            wv = pcw_merge({29'h0, st_reg.fastclk}, st_reg.wdata, st_reg.wstrb);
            st_next.fastclk = wv[2:0];
          end
          `PCW_OFF_PDSTATE: begin
            if (st_reg.wstrb[0]) begin
              st_next.pd_wr = st_reg.wdata[7:0];
            end
          end
          `PCW_OFF_PERCLK: begin
            st_next.misc[7] = pcw_merge(st_reg.misc[7], st_reg.wdata, st_reg.wstrb);
          end
          `PCW_OFF_SELA, `PCW_OFF_SELB, `PCW_OFF_DIV, `PCW_OFF_SELC,
          `PCW_OFF_SLEEP, `PCW_OFF_PSTF, `PCW_OFF_DBGPD: begin // slots 0..6 from 0x10 up
            st_next.misc[3'(st_reg.awaddr[5:2] - 4'h4)] =
              pcw_merge(st_reg.misc[3'(st_reg.awaddr[5:2] - 4'h4)], st_reg.wdata, st_reg.wstrb);
          end
          `PCW_OFF_IRQMSK: begin
            if (st_reg.wstrb[0]) begin
              st_next.irq_msk = st_reg.wdata[2:0];
            end
          end
          `PCW_OFF_IRQSTS: begin
            // status is cleared by reading only
          end
          default: begin
            st_next.bresp = 2'h2;
          end
        endcase
      end
    end

    // register reads, data ready one cycle after the address
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_do) begin
      case ({s_axi_araddr[5:2], 2'h0})
        `PCW_OFF_PWR:     rv = pcw_pwr_word(st_reg.pwr);
        `PCW_OFF_FASTCLK: rv = {29'h0, st_reg.fastclk};
        `PCW_OFF_PERCLK:  rv = st_reg.misc[7];
        `PCW_OFF_PDSTATE: rv = {16'h0, st_reg.pd_rd, st_reg.pd_wr};
        `PCW_OFF_SELA, `PCW_OFF_SELB, `PCW_OFF_DIV, `PCW_OFF_SELC,
        `PCW_OFF_SLEEP, `PCW_OFF_PSTF, `PCW_OFF_DBGPD:
          rv = st_reg.misc[3'(s_axi_araddr[5:2] - 4'h4)];
        `PCW_OFF_IRQSTS:  rv = {29'h0, st_reg.irq_sts};
        `PCW_OFF_IRQMSK:  rv = {29'h0, st_reg.irq_msk};
        default:          rerr = 1'b1;
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata  = rv;
      st_next.rresp  = rerr ? 2'h2 : 2'h0;
      if ({s_axi_araddr[5:2], 2'h0} == `PCW_OFF_IRQSTS) begin
        st_next.irq_sts = 3'h0;
      end
    end

    // power manager
    case (st_reg.pm)
      PCW_RUN: begin
        if (core_wait_instr && (st_reg.pwr.dpd_req || st_reg.pwr.spd_req)) begin
          if (debug_active) begin
            ev[`PCW_IRQ_REFUSE] = 1'b1;
          end else if (st_reg.pwr.dpd_req) begin
            // deep entry, latch, flag clear, timer start
            st_next.pm = PCW_DEEP;
            st_next.pwr.lat_tmr = st_reg.pwr.sel_tmr;
            st_next.pwr.por_f = 1'b0;
            st_next.pwr.tmr_f = 1'b0;
            st_next.pwr.pin_f = 1'b0;
            st_next.tmr_cnt = 11'h000;
            st_next.pd_rd = st_reg.pd_wr;
          end else begin
            st_next.pm = PCW_STBY;
          end
        end
      end
      PCW_DEEP: begin
        if (slow_osc_tick && st_reg.slow_run) begin
          st_next.tmr_cnt = 11'(st_reg.tmr_cnt + 11'h001);
        end
        if (por_event || pin_fall || tmr_hit) begin
          // poweron cause, pin cause, timer cause
          st_next.pwr.por_f = por_event;
          st_next.pwr.pin_f = pin_fall;
          st_next.pwr.tmr_f = tmr_hit;
          st_next.pm = PCW_WAKE;
        end
      end
      PCW_WAKE: begin
        st_next.restart = 1'b1;
        st_next.pwr.dpd_req = 1'b0;
        st_next.pwr.spd_req = 1'b0;
        st_next.pm = PCW_RUN;
        ev[`PCW_IRQ_WAKE] = 1'b1;
      end
      PCW_STBY: begin
        if (standby_wake || por_event) begin
          st_next.pm = PCW_WAKE;
        end
      end
      default: begin
        st_next.pm = PCW_RUN;
      end
    endcase

    // sticky status: a new event wins over the clearing read
    st_next.irq_sts = st_next.irq_sts | ev;
    st_next.irq = |(st_next.irq_sts & st_next.irq_msk);
    // slow oscillator stop in deep, enable
    st_next.slow_run = st_next.pwr.slow_en &&
                       !((st_next.pm == PCW_DEEP) && st_next.pwr.slow_off);
    // power state and ready flags follow the next state so all outputs stay registered
    st_next.awready = !st_next.aw_pend && !st_next.bvalid;
    st_next.wready  = !st_next.w_pend && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    st_next.deep    = (st_next.pm == PCW_DEEP);
    st_next.stby    = (st_next.pm == PCW_STBY);
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.pwr.slow_en <= 1'b1;
      st_reg.pwr.fast_en <= 1'b1;
      st_reg.slow_run    <= 1'b1;
      st_reg.fastclk <= `PCW_RST_FASTCLK;
      st_reg.misc[0] <= `PCW_RST_SELA;
      st_reg.misc[1] <= `PCW_RST_SELB;
      st_reg.misc[2] <= `PCW_RST_DIV;
      st_reg.misc[3] <= `PCW_RST_SELC;
      st_reg.misc[4] <= `PCW_RST_SLEEP;
      st_reg.misc[5] <= `PCW_RST_PSTF;
      st_reg.misc[6] <= `PCW_RST_DBGPD;
      st_reg.misc[7] <= `PCW_RST_PERCLK;
      st_reg.pin_prev <= 1'b1;
      st_reg.awready <= 1'b1;
      st_reg.wready  <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign slow_osc_run               = st_reg.slow_run;
  assign fast_osc_enable            = st_reg.pwr.fast_en;
  assign crystal_osc_enable         = st_reg.pwr.xtal_en;
  assign flash_program_clock_enable = st_reg.fastclk[2];
  assign dma_clock_enable           = st_reg.fastclk[1];
  assign cpu_clock_enable           = st_reg.fastclk[0];
  assign deep_power_down            = st_reg.deep;
  assign standby_power_down         = st_reg.stby;
  assign core_restart               = st_reg.restart;
  assign irq                        = st_reg.irq;

  // checks
  locked_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_lock |=> $stable(st_reg.fastclk) && $stable(st_reg.pwr.sel_tmr) &&
                s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("locked write changed a protected register");
  timer_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(deep_power_down) |-> st_reg.pwr.lat_tmr == $past(st_reg.pwr.sel_tmr))
    else $error("timer setting not latched at deep entry");
  flags_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(deep_power_down) |-> !st_reg.pwr.por_f && !st_reg.pwr.tmr_f && !st_reg.pwr.pin_f)
    else $error("wake flags not cleared at deep entry");
  timer_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tmr_hit |=> st_reg.pwr.tmr_f && st_reg.pm == PCW_WAKE ##1 core_restart)
    else $error("timer wake did not restart the core");
  timer_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_reg.pwr.tmr_f) |-> !$past(st_reg.pwr.slow_off) && $past(slow_osc_run))
    else $error("timed wake with slow oscillator stopped");
  pin_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_reg.pwr.pin_f) |-> !$past(st_reg.pwr.pin_dis) && !$past(wake_pin))
    else $error("pin wake while pin ignored");
  wake_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(deep_power_down) |=> core_restart ##1 !core_restart)
    else $error("deep wake without single restart pulse");
  debug_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.pm == PCW_RUN && core_wait_instr && debug_active &&
     (st_reg.pwr.dpd_req || st_reg.pwr.spd_req)) |=>
      !deep_power_down && !standby_power_down && st_reg.irq_sts[`PCW_IRQ_REFUSE])
    else $error("power down entered while debug active");
  standby_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.pm == PCW_RUN && core_wait_instr && !debug_active && st_reg.pwr.spd_req &&
     !st_reg.pwr.dpd_req) |=> standby_power_down)
    else $error("standby request not honoured");

endmodule : pcw_power_ctrl
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the power control and wake block
`default_nettype none
module tb
  import pcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and bus
  logic        aclk = 0, aresetn = 0;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // system side and controls
  logic        regs_unlocked = 0, core_wait_instr = 0, debug_active = 0, slow_osc_tick = 0;
  logic        wake_pin = 1, por_event = 0, standby_wake = 0;
  logic        slow_osc_run, fast_osc_enable, crystal_osc_enable, flash_program_clock_enable;
  logic        dma_clock_enable, cpu_clock_enable, deep_power_down, standby_power_down;
  logic        core_restart, irq;
  int          mismatches = 0, checks = 0, cyc = 0;
  logic [31:0] d;

  pcw_power_ctrl u_pcw_power_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .regs_unlocked, .core_wait_instr,
    .debug_active, .slow_osc_tick, .wake_pin, .por_event, .standby_wake, .slow_osc_run,
    .fast_osc_enable, .crystal_osc_enable, .flash_program_clock_enable, .dma_clock_enable,
    .cpu_clock_enable, .deep_power_down, .standby_power_down, .core_restart, .irq);

  // free running clock
  always #5 aclk = ~aclk;

  task automatic end_of_test;
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // a hang counts as a mismatch and closes the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // address and data offered together, each dropped when taken; only the timeout ends a wait
  task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rresp, er);
    v = s_axi_rdata;
    s_axi_rready <= 0;
  endtask : rd

  // one wait instruction from the core, then let the state settle
  task automatic sleep_cmd;
    @(posedge aclk) core_wait_instr <= 1;
    @(posedge aclk) core_wait_instr <= 0;
    repeat (2) @(posedge aclk);
  endtask : sleep_cmd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk) slow_osc_tick <= 1;
      @(posedge aclk) slow_osc_tick <= 0;
    end
  endtask : ticks

  // the restart pulse must show within a few cycles of the wake cause
  task automatic woke;
    int n;
    logic seen;
    seen = 0;
    for (n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (core_restart === 1'b1) seen = 1;
    end
    chk(seen, 1);
  endtask : woke

  task automatic t_reset;
    rd(6'h00, 2'h0, d);
    chk(d & 32'h00ffffff, 32'h0000000c);
    rd(6'h04, 2'h0, d);
    chk(d, 32'h00000005);
    chk({slow_osc_run, fast_osc_enable, crystal_osc_enable}, 3'b110);
    chk({flash_program_clock_enable, dma_clock_enable, cpu_clock_enable}, 3'b101);
    rd(6'h34, 2'h2, d);
  endtask : t_reset

  // plain registers: reset values, write and read back, power down state byte
  task automatic t_misc;
    rd(6'h14, 2'h0, d);
    chk(d, 32'h3300771f);
    rd(6'h28, 2'h0, d);
    chk(d, 32'h00000000);
    wr(6'h08, 32'h11110000, 2'h0);
    wr(6'h28, 32'h00000003, 2'h0);
    wr(6'h0c, 32'h000000a5, 2'h0);
    rd(6'h08, 2'h0, d);
    chk(d, 32'h11110000);
    rd(6'h28, 2'h0, d);
    chk(d, 32'h00000003);
    rd(6'h24, 2'h0, d);
    chk(d, 32'h00000000);
    rd(6'h0c, 2'h0, d);
    chk(d, 32'h000000a5);
  endtask : t_misc

  // locked writes are dropped, flagged and raise the masked interrupt
  task automatic t_lock;
    wr(6'h30, 32'h4, 2'h0);
    wr(6'h04, 32'h2, 2'h2);
    rd(6'h04, 2'h0, d);
    chk(d, 32'h5);
    chk(irq, 1);
    rd(6'h2c, 2'h0, d);
    chk(d[2:0], 3'h4);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    regs_unlocked <= 1;
    wr(6'h04, 32'h2, 2'h0);
    repeat (2) @(posedge aclk);
    chk({flash_program_clock_enable, dma_clock_enable, cpu_clock_enable}, 3'b010);
    wr(6'h04, 32'h5, 2'h0);
  endtask : t_lock

  // timer wake at exactly the selected number of slow ticks
  task automatic t_timer(input logic [3:0] sel, input int n);
    // stop bit always written as zero
    wr(6'h00, {8'h00, sel, 20'h0080c}, 2'h0);
    sleep_cmd();
    chk(deep_power_down, 1);
    ticks(n - 1);
    chk(deep_power_down, 1);
    ticks(1);
    woke();
    chk(deep_power_down, 0);
    rd(6'h00, 2'h0, d);
    chk(d, {sel, 4'h2, sel, 20'h0000c});
    rd(6'h0c, 2'h0, d);
    chk(d, 32'h0000a5a5);
  endtask : t_timer

  // slow oscillator stopped, 200 ticks, 56 short of the 256 selected: no timed wake, the pin wakes instead
  task automatic t_pin;
    wr(6'h00, 32'h0022080c, 2'h0);
    sleep_cmd();
    chk(slow_osc_run, 0);
    ticks(200);
    chk(deep_power_down, 1);
    @(posedge aclk) wake_pin <= 0;
    woke();
    wake_pin <= 1;
    rd(6'h00, 2'h0, d);
    chk(d, 32'h2122000c);
  endtask : t_pin

  // pin ignored when disabled, power-on event wakes
  task automatic t_por;
    wr(6'h00, 32'h0001080c, 2'h0);
    sleep_cmd();
    @(posedge aclk) wake_pin <= 0;
    repeat (6) @(posedge aclk);
    chk(deep_power_down, 1);
    wake_pin <= 1;
    @(posedge aclk) por_event <= 1;
    @(posedge aclk) por_event <= 0;
    woke();
    rd(6'h00, 2'h0, d);
    chk(d, 32'h0401000c);
  endtask : t_por

  task automatic t_debug;
    debug_active <= 1;
    wr(6'h00, 32'h0000080c, 2'h0);
    sleep_cmd();
    chk(deep_power_down, 0);
    rd(6'h2c, 2'h0, d);
    chk(d[2:0], 3'h3);
    debug_active <= 0;
  endtask : t_debug

  task automatic t_standby;
    wr(6'h00, 32'h0000040c, 2'h0);
    sleep_cmd();
    chk({deep_power_down, standby_power_down}, 2'b01);
    @(posedge aclk) standby_wake <= 1;
    @(posedge aclk) standby_wake <= 0;
    woke();
    chk(standby_power_down, 0);
    wr(6'h00, 32'h00000002, 2'h0);
    chk({slow_osc_run, fast_osc_enable, crystal_osc_enable}, 3'b001);
  endtask : t_standby

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_misc();
    t_lock();
    t_timer(4'h1, 128);
    t_timer(4'h8, 1024);
    t_pin();
    t_por();
    t_debug();
    t_standby();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
